// *** core/psms_slave.v ***
// Serial management slave: frame decoder, line driver and register access
`timescale 1ns/1ns
`default_nettype none
`include "psms_consts.vh"

module psms_slave #(
    parameter EXT_AW = 5
) (
    // Clock and reset
    input  wire        ref_clk_in,
    input  wire        rst_in,
    // Management pins, line wire-ANDed with a pull-up outside
    input  wire        mgmt_clk_in,
    input  wire        mgmt_data_in,
    output reg         mgmt_data_out,
    output reg         mgmt_data_oe_n_out,
    // Address straps and the captured address
    input  wire [4:0]  bus_address_straps_in,
    output reg  [4:0]  bus_address_out,
    output reg         bus_address_valid_out
);

    // Frame states
    localparam ST_IDLE  = 3'h0;
    localparam ST_START = 3'h1;
    localparam ST_OP    = 3'h2;
    localparam ST_PHY   = 3'h3;
    localparam ST_REG   = 3'h4;
    localparam ST_TA    = 3'h5;
    localparam ST_DATA  = 3'h6;

    localparam EXT_DEPTH = 1 << EXT_AW;

    // Synchronised pins
    wire        mdc_s;
    wire        mdio_s;
    wire [4:0]  straps_s;

    // Edge detection and strap capture
    reg         mdc_prev_ff;
    reg  [1:0]  settle_cnt_ff;

    // Frame decoder state
    reg  [2:0]  state_ff;
    reg  [3:0]  bit_cnt_ff;
    reg  [1:0]  op_ff;
    reg  [4:0]  phy_ff;
    reg  [4:0]  reg_ff;
    reg  [15:0] data_ff;
    reg  [15:0] shout_ff;
    reg         read_sel_ff;

    // Indirect access registers
    reg  [15:0] ind_ctrl_ff;
    reg  [15:0] ind_addr_ff;

    // Access decode
    wire        mdc_rise;
    wire [4:0]  reg_full;
    wire [15:0] wr_word;
    wire        selected;
    wire        op_read;
    wire        op_write;
    wire        rd_take;
    wire        wr_take;
    wire        devad_ok;
    wire [1:0]  func;
    wire        func_data;
    wire [15:0] ext_off;
    wire        tgt_direct;
    wire        tgt_pair;
    wire        tgt_ext;
    wire [15:0] dir_rd_data;
    wire [15:0] ext_rd_data;
    reg  [15:0] rd_word;
    wire [4:0]  frame_addr;
    wire        alias_dir;
    wire [4:0]  acc_addr;
    reg         dir_wr_en;
    reg         ext_wr_en;
    reg         inc_addr;

    // Pins cross into the reference clock domain
    psms_sync #(
        .WIDTH (7)
    ) u_sync (
        .clk_in   (ref_clk_in),
        .rst_in   (rst_in),
        .async_in ({bus_address_straps_in, mgmt_data_in, mgmt_clk_in}),
        .sync_out ({straps_s, mdio_s, mdc_s})
    );

    // Rising edge of the management clock found by oversampling
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mdc_prev_ff <= 1'b0;
        end else begin
            mdc_prev_ff <= mdc_s;
        end
    end

    assign mdc_rise = mdc_s & ~mdc_prev_ff;

    // Straps caught once the synchroniser holds real pin values
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            settle_cnt_ff         <= 2'h0;
            bus_address_out       <= 5'h00;
            bus_address_valid_out <= 1'b0;
        end else if (!bus_address_valid_out) begin
            settle_cnt_ff <= settle_cnt_ff + 2'h1;
            if (settle_cnt_ff == `PSMS_STRAP_SETTLE) begin
                bus_address_out       <= straps_s;
                bus_address_valid_out <= 1'b1;
            end
        end
    end

    // Field values as complete at the deciding edge
    assign reg_full = {reg_ff[3:0], mdio_s};
    assign wr_word  = {data_ff[14:0], mdio_s};
    assign selected = (phy_ff == bus_address_out);
    assign op_read  = (op_ff == `PSMS_OP_READ);
    assign op_write = (op_ff == `PSMS_OP_WRITE);

    assign rd_take  = mdc_rise && (state_ff == ST_REG) && (bit_cnt_ff == 4'h4)
                      && selected && op_read;
    assign wr_take  = mdc_rise && (state_ff == ST_DATA) && (bit_cnt_ff == 4'hf)
                      && selected && op_write;

    // Indirect control fields
    assign devad_ok  = (ind_ctrl_ff[`PSMS_DEVAD_MSB:`PSMS_DEVAD_LSB] == `PSMS_DEVAD_OWN);
    assign func      = ind_ctrl_ff[`PSMS_FUNC_MSB:`PSMS_FUNC_LSB];
    assign func_data = (func != `PSMS_FUNC_ADDR);
    assign ext_off   = ind_addr_ff - `PSMS_EXT_BASE;

    // Extended address decode: low 32 alias the direct set, the pair excluded
    assign tgt_pair   = (ind_addr_ff == {11'h000, `PSMS_REG_IND_CTRL})
                        || (ind_addr_ff == {11'h000, `PSMS_REG_IND_DATA});
    assign tgt_direct = (ind_addr_ff < `PSMS_EXT_BASE) && !tgt_pair;
    assign tgt_ext    = (ind_addr_ff >= `PSMS_EXT_BASE)
                        && (ext_off < EXT_DEPTH);
    assign frame_addr = (state_ff == ST_REG) ? reg_full : reg_ff;
    assign alias_dir  = (frame_addr == `PSMS_REG_IND_DATA) && devad_ok && func_data
                        && tgt_direct;
    assign acc_addr   = alias_dir ? ind_addr_ff[4:0] : frame_addr;

    // Read word and write steering for the current access
    always @* begin
        rd_word   = dir_rd_data;
        dir_wr_en = 1'b0;
        ext_wr_en = 1'b0;
        inc_addr  = 1'b0;
        if (frame_addr == `PSMS_REG_IND_CTRL) begin
            rd_word = ind_ctrl_ff;
        end else if (frame_addr == `PSMS_REG_IND_DATA) begin
            // Foreign device address reads back as zero
            if (!devad_ok) begin
                rd_word = `PSMS_WORD_RESET;
            end else if (!func_data) begin
                rd_word = ind_addr_ff;
            end else if (tgt_direct) begin
                rd_word  = dir_rd_data;
            end else if (tgt_ext) begin
                rd_word = ext_rd_data;
            end else begin
                rd_word = `PSMS_WORD_RESET;
            end
            if (devad_ok && func_data) begin
                dir_wr_en = wr_take && tgt_direct;
                ext_wr_en = wr_take && tgt_ext;
                inc_addr  = (wr_take && (func != `PSMS_FUNC_DATA))
                            || (rd_take && (func == `PSMS_FUNC_INC_RW));
            end
        end else begin
            dir_wr_en = wr_take;
        end
    end

    // Direct register set
    psms_mem #(
        .AW (5),
        .DW (16)
    ) u_direct (
        .clk_in      (ref_clk_in),
        .rst_in      (rst_in),
        .wr_en_in    (dir_wr_en),
        .wr_addr_in  (acc_addr),
        .wr_data_in  (wr_word),
        .rd_addr_in  (acc_addr),
        .rd_data_out (dir_rd_data)
    );

    // Extended register set above the direct aliases
    psms_mem #(
        .AW (EXT_AW),
        .DW (16)
    ) u_ext (
        .clk_in      (ref_clk_in),
        .rst_in      (rst_in),
        .wr_en_in    (ext_wr_en),
        .wr_addr_in  (ext_off[EXT_AW-1:0]),
        .wr_data_in  (wr_word),
        .rd_addr_in  (ext_off[EXT_AW-1:0]),
        .rd_data_out (ext_rd_data)
    );

    // Indirect control and address registers, written only directly
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ind_ctrl_ff <= `PSMS_WORD_RESET;
            ind_addr_ff <= `PSMS_WORD_RESET;
        end else if (wr_take && (reg_ff == `PSMS_REG_IND_CTRL)) begin
            ind_ctrl_ff <= wr_word;
        end else if (wr_take && (reg_ff == `PSMS_REG_IND_DATA) && devad_ok
                     && !func_data) begin
            ind_addr_ff <= wr_word;
        end else if (inc_addr) begin
            ind_addr_ff <= ind_addr_ff + 16'h0001;
        end
    end

    // Frame decoder; moves only on management clock edges, so a
    // stopped clock simply freezes it in whatever field it is in
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff    <= ST_IDLE;
            bit_cnt_ff  <= 4'h0;
            op_ff       <= 2'h0;
            phy_ff      <= 5'h00;
            reg_ff      <= 5'h00;
            data_ff     <= 16'h0000;
            shout_ff    <= 16'h0000;
            read_sel_ff <= 1'b0;
        end else if (mdc_rise && bus_address_valid_out) begin
            case (state_ff)
                ST_IDLE: begin
                    if (!mdio_s) begin
                        state_ff <= ST_START;
                    end
                end
                ST_START: begin
                    // A run of zeros still waits for the one
                    if (mdio_s) begin
                        state_ff   <= ST_OP;
                        bit_cnt_ff <= 4'h0;
                    end
                end
                ST_OP: begin
                    op_ff      <= {op_ff[0], mdio_s};
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    if (bit_cnt_ff == 4'h1) begin
                        state_ff   <= ST_PHY;
                        bit_cnt_ff <= 4'h0;
                    end
                end
                ST_PHY: begin
                    phy_ff     <= {phy_ff[3:0], mdio_s};
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    if (bit_cnt_ff == 4'h4) begin
                        state_ff   <= ST_REG;
                        bit_cnt_ff <= 4'h0;
                    end
                end
                ST_REG: begin
                    reg_ff     <= reg_full;
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    if (bit_cnt_ff == 4'h4) begin
                        // Read data is fetched here, two bits ahead of its first drive
                        state_ff    <= ST_TA;
                        bit_cnt_ff  <= 4'h0;
                        read_sel_ff <= rd_take;
                        shout_ff    <= rd_word;
                    end
                end
                ST_TA: begin
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    if (bit_cnt_ff == 4'h1) begin
                        state_ff   <= ST_DATA;
                        bit_cnt_ff <= 4'h0;
                        if (read_sel_ff) begin
                            shout_ff <= {shout_ff[14:0], 1'b0};
                        end
                    end
                end
                ST_DATA: begin
                    data_ff    <= wr_word;
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    if (read_sel_ff) begin
                        shout_ff <= {shout_ff[14:0], 1'b0};
                    end
                    if (bit_cnt_ff == 4'hf) begin
                        state_ff    <= ST_IDLE;
                        bit_cnt_ff  <= 4'h0;
                        read_sel_ff <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Line driver; changes just after the edge the station samples on,
    // giving it nearly a whole management clock period of setup
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mgmt_data_out      <= 1'b1;
            mgmt_data_oe_n_out <= 1'b1;
        end else if (mdc_rise) begin
            if ((state_ff == ST_TA) && (bit_cnt_ff == 4'h0) && read_sel_ff) begin
                mgmt_data_out      <= 1'b0;
                mgmt_data_oe_n_out <= 1'b0;
            end else if ((state_ff == ST_TA) && (bit_cnt_ff == 4'h1) && read_sel_ff) begin
                mgmt_data_out      <= shout_ff[15];
                mgmt_data_oe_n_out <= 1'b0;
            end else if ((state_ff == ST_DATA) && (bit_cnt_ff != 4'hf) && read_sel_ff) begin
                mgmt_data_out      <= shout_ff[15];
                mgmt_data_oe_n_out <= 1'b0;
            end else begin
                // Writes, foreign frames and idle leave the line alone
                mgmt_data_out      <= 1'b1;
                mgmt_data_oe_n_out <= 1'b1;
            end
        end
    end

endmodule // psms_slave

`default_nettype wire

// *** core/psms_consts.vh ***
// Constants for the PHY serial management slave
`ifndef PSMS_CONSTS_VH
`define PSMS_CONSTS_VH

// Field widths of a management frame
`define PSMS_OP_BITS        2
`define PSMS_ADDR_BITS      5
`define PSMS_DATA_BITS      16

// Operation codes, first bit on the wire in bit 1
`define PSMS_OP_READ        2'h2
`define PSMS_OP_WRITE       2'h1

// Direct register offsets of the indirect access pair
`define PSMS_REG_IND_CTRL   5'h0d
`define PSMS_REG_IND_DATA   5'h0e

// Indirect control word fields
`define PSMS_DEVAD_LSB      0
`define PSMS_DEVAD_MSB      4
`define PSMS_FUNC_LSB       14
`define PSMS_FUNC_MSB       15
`define PSMS_DEVAD_OWN      5'h1f
`define PSMS_FUNC_ADDR      2'h0
`define PSMS_FUNC_DATA      2'h1
`define PSMS_FUNC_INC_RW    2'h2
`define PSMS_FUNC_INC_WR    2'h3

// Extended space above the 32 direct registers
`define PSMS_EXT_BASE       16'h0020

// Reset values
`define PSMS_WORD_RESET     16'h0000

// Strap capture waits for the synchroniser to fill after reset release
`define PSMS_STRAP_SETTLE   2'h3

// Management clock limit and the matching least period in local cycles
`define PSMS_MDC_MAX_MHZ    25
`define PSMS_REF_CLK_MHZ    125
`define PSMS_MDC_MIN_CYCLES ((`PSMS_REF_CLK_MHZ + `PSMS_MDC_MAX_MHZ - 1) / `PSMS_MDC_MAX_MHZ)

`endif

// *** core/psms_sync.v ***
// Two-stage synchroniser for pins entering the reference clock domain
`timescale 1ns/1ns
`default_nettype none

module psms_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clk_in,
    input  wire             rst_in,
    // Asynchronous pins and their synchronised copies
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;

    // One chain per bit; the first stage feeds only the second
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_ff;
            reg stable_ff;
            always @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    meta_ff   <= 1'b0;
                    stable_ff <= 1'b0;
                end else begin
                    meta_ff   <= async_in[i];
                    stable_ff <= meta_ff;
                end
            end
            assign sync_out[i] = stable_ff;
        end
    endgenerate

endmodule // psms_sync

`default_nettype wire

// *** core/psms_mem.v ***
// Register storage array with one write port and one read port
`timescale 1ns/1ns
`default_nettype none

module psms_mem #(
    parameter AW = 5,
    parameter DW = 16
) (
    // Clock and reset
    input  wire          clk_in,
    input  wire          rst_in,
    // Write port
    input  wire          wr_en_in,
    input  wire [AW-1:0] wr_addr_in,
    input  wire [DW-1:0] wr_data_in,
    // Combinational read port
    input  wire [AW-1:0] rd_addr_in,
    output wire [DW-1:0] rd_data_out
);

    reg [DW-1:0] word_ff [0:(1<<AW)-1];
    integer      k;

    // Reset every word so read data is never unknown on the line
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (k = 0; k < (1 << AW); k = k + 1) begin
                word_ff[k] <= {DW{1'b0}};
            end
        end else if (wr_en_in) begin
            word_ff[wr_addr_in] <= wr_data_in;
        end
    end

    assign rd_data_out = word_ff[rd_addr_in];

endmodule // psms_mem

`default_nettype wire

// *** sim/psms_station_model.sv ***
// Station side model: makes the management clock and frames transfers
`timescale 1ns/1ns
`default_nettype none
`include "psms_consts.vh"

module psms_station_model (
    // Pacing clock
    input  wire logic ref_clk_in,
    // Slave line driver
    input  wire logic slv_data_in,
    input  wire logic slv_oe_n_in,
    // Management pins
    output var  logic mgmt_clk_out,
    output wire logic line_out
);
    logic sta_oe;
    logic sta_d;

    // Wired-AND with pull-up, so a released party reads high
    assign line_out = (sta_oe ? sta_d : 1'b1) & (slv_oe_n_in ? 1'b1 : slv_data_in);

    // Clock parked low and line released between frames
    initial begin
        mgmt_clk_out = 1'b0;
        sta_oe = 1'b0;
        sta_d = 1'b1;
    end

    // Two idle bits then 32 frame bits; 64 ns period, longer than the 40 ns least period of the limit
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                        input logic [15:0] wd, output logic [17:0] smp);
        logic [33:0] bits;
        bits = {2'b11, 2'b01, op, phy, rg, 2'b10, wd};
        for (int i = 33; i >= 0; i--) begin
            // Reads hand the line over from the first turnaround bit on
            sta_oe = (i < 32) && (op != `PSMS_OP_READ || i > 17);
            sta_d = bits[i];
            repeat (4) @(negedge ref_clk_in);
            if (i < 18) smp[i] = line_out;
            mgmt_clk_out = 1'b1;
            repeat (4) @(negedge ref_clk_in);
            mgmt_clk_out = 1'b0;
        end
        // Release, then let an edge pass before the next frame drives
        sta_oe = 1'b0;
        @(negedge ref_clk_in);
    endtask
endmodule // psms_station_model

`default_nettype wire

// *** sim/psms_slave_sva.sv ***
// Port checker for the serial management slave
`timescale 1ns/1ns
`default_nettype none

module psms_slave_sva (
    // Clock and reset
    input wire logic       ref_clk_in,
    input wire logic       rst_in,
    // Management pins
    input wire logic       mgmt_clk_in,
    input wire logic       mgmt_data_in,
    input wire logic       mgmt_data_out,
    input wire logic       mgmt_data_oe_n_out,
    // Address
    input wire logic [4:0] bus_address_straps_in,
    input wire logic [4:0] bus_address_out,
    input wire logic       bus_address_valid_out
);
    logic       mclk_q_ff;
    logic [3:0] since_ff;
    logic [4:0] rises_ff;
    logic       rise;

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // Raw clock rise, ahead of the slave's synchroniser
    assign rise = mgmt_clk_in & ~mclk_q_ff;

    // Cycles since last rise (saturating), rises counted while driving
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mclk_q_ff <= 1'b0;
            since_ff <= 4'hf;
            rises_ff <= 5'h00;
        end else begin
            mclk_q_ff <= mgmt_clk_in;
            since_ff <= rise ? 4'h0 : ((since_ff == 4'hf) ? 4'hf : since_ff + 4'h1);
            rises_ff <= mgmt_data_oe_n_out ? 5'h00 : rises_ff + {4'h0, rise};
        end
    end

    sequence s_drive_start;
        $fell(mgmt_data_oe_n_out);
    endsequence
    sequence s_drive_end;
        $rose(mgmt_data_oe_n_out);
    endsequence

    a_released_high: assert property (mgmt_data_oe_n_out |-> mgmt_data_out)
        else $error("released driver not high");
    a_quiet_unbound: assert property (!bus_address_valid_out |-> mgmt_data_oe_n_out)
        else $error("drive before address capture");
    a_valid_holds: assert property (bus_address_valid_out |=> bus_address_valid_out)
        else $error("address valid dropped");
    a_addr_kept: assert property (bus_address_valid_out |=> $stable(bus_address_out))
        else $error("captured address changed");
    a_addr_strapped: assert property ($rose(bus_address_valid_out) |->
        bus_address_out == bus_address_straps_in) else $error("address differs from straps");
    a_ta_zero: assert property (s_drive_start |-> !mgmt_data_out)
        else $error("second turnaround bit not zero");
    a_after_ta_one: assert property (s_drive_start |-> since_ff inside {[2:6]})
        else $error("drive began outside turnaround edge");
    a_drive_span: assert property (s_drive_end |-> rises_ff == 5'h11)
        else $error("drive span not seventeen bits");
    a_bit_timing: assert property ((!mgmt_data_oe_n_out && !$past(mgmt_data_oe_n_out) &&
        $changed(mgmt_data_out)) |-> since_ff inside {[2:6]}) else $error("bit changed off edge");
    a_idle_steady: assert property (since_ff == 4'hf |->
        $stable(mgmt_data_oe_n_out) && $stable(mgmt_data_out)) else $error("change on idle clock");
endmodule // psms_slave_sva

bind psms_slave psms_slave_sva u_psms_slave_sva (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .mgmt_clk_in(mgmt_clk_in),
    .mgmt_data_in(mgmt_data_in), .mgmt_data_out(mgmt_data_out),
    .mgmt_data_oe_n_out(mgmt_data_oe_n_out), .bus_address_straps_in(bus_address_straps_in),
    .bus_address_out(bus_address_out), .bus_address_valid_out(bus_address_valid_out)
);

`default_nettype wire

// *** sim/psms_slave_tb_top.sv ***
// Self-checking bench for the serial management slave
`timescale 1ns/1ns
`default_nettype none
`include "psms_consts.vh"

module psms_slave_tb_top;
    logic       ref_clk;
    logic       rst;
    logic [4:0] straps;
    logic       mclk;
    logic       line;
    logic       sdata;
    logic       soe_n;
    logic [4:0] adr;
    logic       adr_ok;
    logic [4:0] own;
    int         miscompares;
    int         n_compared;

    psms_slave #(.EXT_AW(5)) u_psms_slave (
        .ref_clk_in(ref_clk), .rst_in(rst), .mgmt_clk_in(mclk), .mgmt_data_in(line),
        .mgmt_data_out(sdata), .mgmt_data_oe_n_out(soe_n), .bus_address_straps_in(straps),
        .bus_address_out(adr), .bus_address_valid_out(adr_ok)
    );
    psms_station_model u_psms_station_model (
        .ref_clk_in(ref_clk), .slv_data_in(sdata), .slv_oe_n_in(soe_n),
        .mgmt_clk_out(mclk), .line_out(line)
    );

    // 125 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic chk_frame(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_addr(input logic [4:0] got, input logic [4:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Line during a write carries only station bits: slave stays off
    task automatic wr(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d,
                      input logic [1:0] op);
        logic [17:0] s;
        u_psms_station_model.xfer(op, phy, rg, d, s);
        chk_frame(s, {2'b10, d});
    endtask
    // Foreign address leaves the line pulled high throughout
    task automatic rd(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] e);
        logic [17:0] s;
        u_psms_station_model.xfer(`PSMS_OP_READ, phy, rg, 16'h0000, s);
        chk_frame(s, (phy == own) ? {2'b10, e} : 18'h3ffff);
    endtask

    // Reset with given straps, then wait a bounded time for capture
    task automatic do_reset(input logic [4:0] st);
        int n;
        rst = 1'b1;
        straps = st;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        for (n = 0; n < 50 && adr_ok !== 1'b1; n++) @(negedge ref_clk);
        if (adr_ok !== 1'b1) begin
            miscompares++;
            give_verdict();
        end
        chk_addr(adr, st);
        own = st;
    endtask

    // All direct registers but the indirect pair written first, so aliasing shows on read-back
    task automatic t_direct();
        for (int i = 0; i < 32; i++)
            if (i != 13 && i != 14) wr(own, i[4:0], 16'hc3a5 ^ i[15:0], `PSMS_OP_WRITE);
        for (int i = 0; i < 32; i++)
            if (i != 13 && i != 14) rd(own, i[4:0], 16'hc3a5 ^ i[15:0]);
    endtask
    // Foreign address and unknown codes change nothing
    task automatic t_refused();
        wr(own ^ 5'h01, 5'h03, 16'h0bad, `PSMS_OP_WRITE);
        rd(own ^ 5'h01, 5'h03, 16'h0000);
        wr(own, 5'h03, 16'h1234, 2'h0);
        wr(own, 5'h03, 16'h4321, 2'h3);
        rd(own, 5'h03, 16'hc3a6);
    endtask
    // Step table: bit 21 read, bits 20:16 register, 15:0 data or expectation
    task automatic t_indirect();
        logic [21:0] st [34] = '{22'h0d001f, 22'h0e0021, 22'h2e0021, 22'h0d401f, 22'h0ebeef,
            22'h2ebeef, 22'h2ebeef, 22'h0d801f, 22'h2ebeef, 22'h0e2222, 22'h0dc01f, 22'h2e0000,
            22'h0e3333, 22'h2e0000, 22'h0d001f, 22'h2e0024, 22'h0e0022, 22'h0d401e, 22'h2e0000,
            22'h0e5555, 22'h0d401f, 22'h2e2222, 22'h0d001f, 22'h0e000d, 22'h0d401f, 22'h0e7777,
            22'h2e0000, 22'h2d401f, 22'h0d001f, 22'h0e0003, 22'h0d401f, 22'h2ec3a6, 22'h0e0abc,
            22'h230abc};
        foreach (st[i])
            if (st[i][21]) rd(own, st[i][20:16], st[i][15:0]);
            else wr(own, st[i][20:16], st[i][15:0], `PSMS_OP_WRITE);
    endtask
    // Second reset relatches new straps and clears registers
    task automatic t_rereset();
        do_reset(5'h0a);
        rd(5'h0a, 5'h03, 16'h0000);
        rd(5'h15, 5'h03, 16'h0000);
    endtask

    // Main sequence
    initial begin
        miscompares = 0;
        n_compared = 0;
        rst = 1'b1;
        straps = 5'h15;
        own = 5'h15;
        @(negedge ref_clk);
        do_reset(5'h15);
        t_direct();
        t_refused();
        t_indirect();
        t_rereset();
        give_verdict();
    end
    // Hang guard, about 75k reference cycles
    initial begin
        #600000;
        miscompares++;
        give_verdict();
    end
endmodule // psms_slave_tb_top

`default_nettype wire
